// [include/fsp_map.vh]
// ============================================================
// Serial flash sequencer constants
// ============================================================
// Holds command codes, status bit positions, array geometry, array
// operation codes and cycle timing counts for the flash sequencer.
// Assumes the including module runs its system clock at 50 MHz.
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// Command codes
`define FSP_CMD_WREN 8'h06
`define FSP_CMD_WRDI 8'h04
`define FSP_CMD_RDSR 8'h05
`define FSP_CMD_WRSR 8'h01
`define FSP_CMD_PP 8'h02
`define FSP_CMD_SE 8'hd8
`define FSP_CMD_BE 8'hc7
`define FSP_CMD_DPD 8'hb9
`define FSP_CMD_RDPD 8'hab

// Status register bit positions
`define FSP_SR_WIP 0
`define FSP_SR_WEL 1
`define FSP_SR_BP_LO 2
`define FSP_SR_BP_HI 4
`define FSP_SR_LOCK 7

// Array geometry
`define FSP_PAGE_BYTES 256
`define FSP_ERASED_BYTE 8'hff

// Array operation codes on the array port
`define FSP_OP_PROG 2'h1
`define FSP_OP_SECT 2'h2
`define FSP_OP_BULK 2'h3

// Timing: times in ms, clock rate in cycles per ms
`define FSP_CLK_PER_MS 50000
`define FSP_PP_TIME_MS 5
`define FSP_SE_TIME_MS 3000
`define FSP_BE_TIME_MS 40000
`define FSP_W_TIME_MS 15
`define FSP_PUW_TIME_MS 10
`define FSP_PP_CYC (`FSP_PP_TIME_MS * `FSP_CLK_PER_MS)
`define FSP_SE_CYC (`FSP_SE_TIME_MS * `FSP_CLK_PER_MS)
`define FSP_BE_CYC (`FSP_BE_TIME_MS * `FSP_CLK_PER_MS)
`define FSP_W_CYC (`FSP_W_TIME_MS * `FSP_CLK_PER_MS)
`define FSP_PUW_CYC (`FSP_PUW_TIME_MS * `FSP_CLK_PER_MS)

`endif

// [rtl/fsp_flash_seq.v]
// Serial flash program, erase and protect sequencer.
// Assumes the serial pins arrive asynchronously and are oversampled
// by i_clk_sys; the array itself sits outside behind the array port.
`timescale 1ns/10ps
`include "fsp_map.vh"

module fsp_flash_seq #(
	parameter [31:0] P_PP_CYC = `FSP_PP_CYC,
	parameter [31:0] P_SE_CYC = `FSP_SE_CYC,
	parameter [31:0] P_BE_CYC = `FSP_BE_CYC,
	parameter [31:0] P_W_CYC = `FSP_W_CYC,
	parameter [31:0] P_PUW_CYC = `FSP_PUW_CYC
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// Serial link pins
	input wire i_sclk,
	input wire i_sel_n,
	input wire i_serial_in,
	input wire i_pause_n,
	input wire i_wprot_n,
	output reg o_serial_out,
	output wire o_serial_out_oe,
	// Array port
	output wire o_arr_valid,
	output wire [1:0] o_arr_op,
	output wire [21:0] o_arr_addr,
	output wire [7:0] o_arr_data,
	input wire i_arr_ready,
	// Status and mode
	output wire [7:0] o_status,
	output wire o_active,
	output wire o_deep_pd,
	output wire o_paused
);

	// ============================================================
	// Local constants
	// ============================================================
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_DRAIN = 3'b010;
	localparam [2:0] S_WAIT = 3'b100;

	// ============================================================
	// Input synchronisers
	// ============================================================
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg sclk_prev_q;
	reg sel_prev_q;
	reg pause_prev_q;
	wire sclk_s = sync2_q[0];
	wire sel_n_s = sync2_q[1];
	wire sin_s = sync2_q[2];
	wire pause_n_s = sync2_q[3];
	wire wprot_n_s = sync2_q[4];

	// Two flops per pin, then edge history from the second stage
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 5'h1e;
			sync2_q <= 5'h1e;
			sclk_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
			pause_prev_q <= 1'b1;
		end else begin
			sync1_q <= {i_wprot_n, i_pause_n, i_serial_in, i_sel_n, i_sclk};
			sync2_q <= sync1_q;
			sclk_prev_q <= sclk_s;
			sel_prev_q <= sel_n_s;
			pause_prev_q <= pause_n_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire sclk_fall = ~sclk_s & sclk_prev_q;
	wire sel_rise = sel_n_s & ~sel_prev_q;
	wire pause_fall = ~pause_n_s & pause_prev_q;
	wire pause_rise = pause_n_s & ~pause_prev_q;

	// ============================================================
	// Pause condition
	// ============================================================
	reg pause_q;
	reg pend_on_q;
	reg pend_off_q;

	// pause timing
	// Entry and exit wait for the serial clock to be low
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pause_q <= 1'b0;
			pend_on_q <= 1'b0;
			pend_off_q <= 1'b0;
		end else if (sel_n_s) begin
			pause_q <= 1'b0;
			pend_on_q <= 1'b0;
			pend_off_q <= 1'b0;
		end else if (pause_fall) begin
			pend_off_q <= 1'b0;
			pend_on_q <= sclk_s;
			if (!sclk_s)
				pause_q <= 1'b1;
		end else if (pause_rise) begin
			pend_on_q <= 1'b0;
			pend_off_q <= sclk_s;
			if (!sclk_s)
				pause_q <= 1'b0;
		end else if (pend_on_q && !sclk_s) begin
			pend_on_q <= 1'b0;
			pause_q <= 1'b1;
		end else if (pend_off_q && sclk_fall) begin
			pend_off_q <= 1'b0;
			pause_q <= 1'b0;
		end
	end

	// ============================================================
	// Serial interface, command execution and sequencer
	// ============================================================
	reg [2:0] bit_cnt_q;
	reg [9:0] byte_cnt_q;
	reg [6:0] shift_q;
	reg [7:0] cmd_q;
	reg [23:0] addr_q;
	reg [7:0] data_q;
	reg rd_stat_q;
	reg [2:0] out_idx_q;
	reg wel_q;
	reg [2:0] bp_q;
	reg lock_q;
	reg dpd_q;
	reg [2:0] state_q;
	reg [1:0] op_q;
	reg [21:0] op_addr_q;
	reg [8:0] drain_idx_q;
	reg [31:0] timer_q;
	reg [31:0] puw_q;
	reg [7:0] pbuf [0:`FSP_PAGE_BYTES-1];
	integer i;

	// busy flag
	// High from cycle start until the sequencer returns to idle
	wire cycle_in_progress_flag = (state_q != S_IDLE);
	wire [7:0] stat = {lock_q, 2'h0, bp_q, wel_q, cycle_in_progress_flag};
	wire shift_ok = ~sel_n_s & ~pause_q;
	wire [7:0] byte_in = {shift_q, sin_s};
	wire byte_done = shift_ok & sclk_rise & (bit_cnt_q == 3'h7);
	wire [7:0] pb_idx = addr_q[7:0] + byte_cnt_q[7:0] - 8'h04;

	function [6:0] prot_lo;
		input [2:0] bp;
		begin
			case (bp)
				3'h0: prot_lo = 7'h40;
				3'h1: prot_lo = 7'h3f;
				3'h2: prot_lo = 7'h3e;
				3'h3: prot_lo = 7'h3c;
				3'h4: prot_lo = 7'h38;
				3'h5: prot_lo = 7'h30;
				3'h6: prot_lo = 7'h20;
				default: prot_lo = 7'h00;
			endcase
		end
	endfunction

	wire addr_prot = ({1'b0, addr_q[21:16]} >= prot_lo(bp_q));
	wire byte_edge = (bit_cnt_q == 3'h0);
	// modify allowed only if enabled, awake, idle
	wire mod_ok = wel_q & ~dpd_q & ~cycle_in_progress_flag & byte_edge;
	wire fifo_in_ready;
	wire push = (state_q == S_DRAIN) & fifo_in_ready;
	wire [8:0] drain_last = (op_q == `FSP_OP_PROG) ? 9'h0ff : 9'h000;

	// Page buffer: refilled with erased value, data bytes AND in
	always @(posedge i_clk_sys) begin
		if (byte_done && !cycle_in_progress_flag && byte_cnt_q == 10'h000) begin
			for (i = 0; i < `FSP_PAGE_BYTES; i = i + 1)
				pbuf[i] <= `FSP_ERASED_BYTE;
		end else if (byte_done && !cycle_in_progress_flag && cmd_q == `FSP_CMD_PP && byte_cnt_q >= 10'h004) begin
			// wrap within page, clear bits only
			pbuf[pb_idx] <= pbuf[pb_idx] & byte_in;
		end
	end

	// Main control: shifter, decode on deselect, cycle sequencer
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 10'h000;
			shift_q <= 7'h00;
			cmd_q <= 8'h00;
			addr_q <= 24'h000000;
			data_q <= 8'h00;
			rd_stat_q <= 1'b0;
			out_idx_q <= 3'h0;
			o_serial_out <= 1'b0;
			wel_q <= 1'b0;
			bp_q <= 3'h0;
			lock_q <= 1'b0;
			dpd_q <= 1'b0;
			state_q <= S_IDLE;
			op_q <= 2'h0;
			op_addr_q <= 22'h000000;
			drain_idx_q <= 9'h000;
			timer_q <= 32'h00000000;
			puw_q <= P_PUW_CYC;
		end else begin
			if (puw_q != 32'h00000000)
				puw_q <= puw_q - 32'h00000001;
			if (sel_n_s) begin
				bit_cnt_q <= 3'h0;
				byte_cnt_q <= 10'h000;
				rd_stat_q <= 1'b0;
				out_idx_q <= 3'h0;
			end else if (shift_ok && sclk_rise) begin
				shift_q <= byte_in[6:0];
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (byte_done) begin
					if (byte_cnt_q != 10'h3ff)
						byte_cnt_q <= byte_cnt_q + 10'h001;
					if (byte_cnt_q == 10'h000) begin
						cmd_q <= byte_in;
						rd_stat_q <= (byte_in == `FSP_CMD_RDSR) & ~dpd_q;
					end
					if (byte_cnt_q == 10'h001)
						addr_q[23:16] <= byte_in;
					if (byte_cnt_q == 10'h001)
						data_q <= byte_in;
					if (byte_cnt_q == 10'h002)
						addr_q[15:8] <= byte_in;
					if (byte_cnt_q == 10'h003)
						addr_q[7:0] <= byte_in;
				end
			end else if (shift_ok && sclk_fall && rd_stat_q) begin
				// status bits shift out on falling clock
				o_serial_out <= stat[3'h7 - out_idx_q];
				out_idx_q <= out_idx_q + 3'h1;
			end

			// Internal cycle sequencer, runs on regardless of pause
			case (state_q)
				S_IDLE: begin
				end
				S_DRAIN: begin
					if (timer_q != 32'h00000000)
						timer_q <= timer_q - 32'h00000001;
					if (push) begin
						drain_idx_q <= drain_idx_q + 9'h001;
						if (drain_idx_q == drain_last)
							state_q <= S_WAIT;
					end
				end
				S_WAIT: begin
					// flag clears only when cycle ends
					// Busy also covers words still queued for the array
					if (timer_q != 32'h00000000)
						timer_q <= timer_q - 32'h00000001;
					else if (!o_arr_valid) begin
						state_q <= S_IDLE;
						wel_q <= 1'b0;
					end
				end
				default: state_q <= S_IDLE;
			endcase

			// Command execution on the deselecting edge
			if (sel_rise && !pause_q) begin
				case (cmd_q)
					`FSP_CMD_WREN: begin
						if (byte_cnt_q == 10'h001 && byte_edge && !dpd_q && !cycle_in_progress_flag && puw_q == 32'h00000000)
							wel_q <= 1'b1;
					end
					`FSP_CMD_WRDI: begin
						if (byte_cnt_q == 10'h001 && byte_edge && !dpd_q && !cycle_in_progress_flag)
							wel_q <= 1'b0;
					end
					`FSP_CMD_WRSR: begin
						if (mod_ok && byte_cnt_q == 10'h002 && wprot_n_s) begin
							bp_q <= data_q[`FSP_SR_BP_HI:`FSP_SR_BP_LO];
							lock_q <= data_q[`FSP_SR_LOCK];
							timer_q <= P_W_CYC;
							state_q <= S_WAIT;
						end
					end
					`FSP_CMD_PP: begin
						if (mod_ok && byte_cnt_q >= 10'h005 && !addr_prot) begin
							op_q <= `FSP_OP_PROG;
							op_addr_q <= {addr_q[21:8], 8'h00};
							drain_idx_q <= 9'h000;
							timer_q <= P_PP_CYC;
							state_q <= S_DRAIN;
						end
					end
					`FSP_CMD_SE: begin
						if (mod_ok && byte_cnt_q == 10'h004 && !addr_prot) begin
							op_q <= `FSP_OP_SECT;
							op_addr_q <= {addr_q[21:16], 16'h0000};
							drain_idx_q <= 9'h000;
							timer_q <= P_SE_CYC;
							state_q <= S_DRAIN;
						end
					end
					`FSP_CMD_BE: begin
						// bulk erase needs guard bits zero
						if (mod_ok && byte_cnt_q == 10'h001 && bp_q == 3'h0) begin
							op_q <= `FSP_OP_BULK;
							op_addr_q <= 22'h000000;
							drain_idx_q <= 9'h000;
							timer_q <= P_BE_CYC;
							state_q <= S_DRAIN;
						end
					end
					`FSP_CMD_DPD: begin
						if (byte_cnt_q == 10'h001 && byte_edge && !cycle_in_progress_flag)
							dpd_q <= 1'b1;
					end
					`FSP_CMD_RDPD: begin
						if (byte_cnt_q != 10'h000)
							dpd_q <= 1'b0;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ============================================================
	// Two-entry array request buffer
	// ============================================================
	reg [31:0] head_q;
	reg [31:0] tail_q;
	reg [1:0] fcnt_q;
	wire [7:0] pb_word = (op_q == `FSP_OP_PROG) ? pbuf[drain_idx_q[7:0]] : `FSP_ERASED_BYTE;
	wire [31:0] in_word = {op_q, op_addr_q[21:8], op_addr_q[7:0] | drain_idx_q[7:0], pb_word};
	wire pop = (fcnt_q != 2'h0) & i_arr_ready;
	assign fifo_in_ready = (fcnt_q != 2'h2);

	// Head feeds the array port directly; stalls back-press the drain
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			head_q <= 32'h00000000;
			tail_q <= 32'h00000000;
			fcnt_q <= 2'h0;
		end else begin
			if (pop) begin
				if (fcnt_q == 2'h2)
					head_q <= tail_q;
				else if (push)
					head_q <= in_word;
				if (fcnt_q == 2'h2 && push)
					tail_q <= in_word;
			end else if (push) begin
				if (fcnt_q == 2'h0)
					head_q <= in_word;
				else
					tail_q <= in_word;
			end
			fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// ============================================================
	// Outputs
	// ============================================================
	assign o_arr_valid = (fcnt_q != 2'h0);
	assign o_arr_op = head_q[31:30];
	assign o_arr_addr = head_q[29:8];
	assign o_arr_data = head_q[7:0];
	assign o_status = stat;
	assign o_serial_out_oe = ~sel_n_s & rd_stat_q & ~pause_q;
	assign o_active = ~sel_n_s | cycle_in_progress_flag;
	assign o_deep_pd = dpd_q;
	assign o_paused = pause_q;

endmodule // fsp_flash_seq

// [testbench/fsp_flash_seq_tb.sv]
// Self-checking bench for the flash sequencer.
// Assumes fsp_map.vh on the include path; array model is a recorder.
`timescale 1ns/10ps
`include "fsp_map.vh"
module fsp_flash_seq_tb;
	logic clk_sys, rst_n, wprot_n, arr_ready;
	wire sclk, sel_n, mosi, pause_n, sout, sout_oe, arr_valid, active, deep_pd, paused;
	wire [1:0] arr_op;
	wire [21:0] arr_addr;
	wire [7:0] arr_data, status;
	int miscompares = 0, num_checks = 0, cnt = 0, lo_t[8] = '{64, 63, 62, 60, 56, 48, 32, 0};
	logic [31:0] q[$];
	logic [7:0] r;

	fsp_flash_seq #(.P_PP_CYC(200), .P_SE_CYC(300), .P_BE_CYC(400), .P_W_CYC(50), .P_PUW_CYC(20)) i_fsp_flash_seq (
		.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_sclk(sclk), .i_sel_n(sel_n), .i_serial_in(mosi),
		.i_pause_n(pause_n), .i_wprot_n(wprot_n), .o_serial_out(sout), .o_serial_out_oe(sout_oe),
		.o_arr_valid(arr_valid), .o_arr_op(arr_op), .o_arr_addr(arr_addr), .o_arr_data(arr_data),
		.i_arr_ready(arr_ready), .o_status(status), .o_active(active), .o_deep_pd(deep_pd), .o_paused(paused));
	fsp_spi_master i_fsp_spi_master (.o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi), .o_pause_n(pause_n), .i_miso(sout));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Array side: stalls one cycle in three and records taken words
	always @(posedge clk_sys) begin
		cnt <= cnt + 1;
		arr_ready <= #1 (cnt % 3 != 0);
		if (arr_valid === 1'b1 && arr_ready === 1'b1)
			q.push_back({arr_op, arr_addr, arr_data});
	end

	// ============================================================
	// Helpers
	// ============================================================
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task summarize;
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task b8(input logic [7:0] d);
		i_fsp_spi_master.bits(d, 8, r);
	endtask

	task cmd(input logic [7:0] c);
		i_fsp_spi_master.start();
		b8(c);
		i_fsp_spi_master.stop();
	endtask

	task hdr(input logic [7:0] c, input logic [23:0] a);
		q.delete();
		i_fsp_spi_master.start();
		b8(c);
		b8(a[23:16]);
		b8(a[15:8]);
		b8(a[7:0]);
	endtask

	task idle;
		int n;
		n = 0;
		while (status[0] !== 1'b0 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("idle", n < 3000, 1);
	endtask

	task wrsr(input logic [2:0] b);
		cmd(`FSP_CMD_WREN);
		i_fsp_spi_master.start();
		b8(`FSP_CMD_WRSR);
		b8({3'h0, b, 2'h0});
		i_fsp_spi_master.stop();
		idle();
	endtask

	// ============================================================
	// Scenarios
	// ============================================================
	task s_latch;
		hdr(`FSP_CMD_PP, 24'h000000);
		b8(8'haa);
		i_fsp_spi_master.stop();
		chk("pp no enable", {status[0], 24'(q.size())}, 0);
		cmd(`FSP_CMD_WREN);
		i_fsp_spi_master.start();
		b8(`FSP_CMD_RDSR);
		b8(8'h00);
		i_fsp_spi_master.stop();
		chk("status read", r, 8'h02);
		cmd(`FSP_CMD_WRDI);
		chk("latch cleared", status[1], 0);
		cmd(`FSP_CMD_WREN);
		i_fsp_spi_master.start();
		b8(`FSP_CMD_WRDI);
		i_fsp_spi_master.bits(8'h00, 4, r);
		i_fsp_spi_master.stop();
		chk("odd length", status[1], 1);
	endtask

	task s_prog;
		int i;
		cmd(`FSP_CMD_WREN);
		hdr(`FSP_CMD_PP, 24'h0001f0);
		b8(8'ha5);
		b8(8'h3c);
		i_fsp_spi_master.stop();
		chk("busy active", {status[0], active}, 2'h3);
		idle();
		chk("page words", q.size(), 256);
		for (i = 0; i < 256; i++)
			chk("page word", q[i], {`FSP_OP_PROG, 22'h100 + 22'(i), i == 240 ? 8'ha5 : i == 241 ? 8'h3c : 8'hff});
		chk("latch done", status[1], 0);
	endtask

	task s_protect;
		int b;
		for (b = 1; b < 8; b++) begin
			wrsr(3'(b));
			chk("guard bits", status[4:2], b);
			cmd(`FSP_CMD_WREN);
			hdr(`FSP_CMD_SE, {2'h0, 6'(lo_t[b]), 16'h0});
			i_fsp_spi_master.stop();
			chk("guarded erase", {status[0], 24'(q.size())}, 0);
			if (lo_t[b] > 0) begin
				cmd(`FSP_CMD_WREN);
				hdr(`FSP_CMD_SE, {2'h0, 6'(lo_t[b] - 1), 16'h0});
				i_fsp_spi_master.stop();
				idle();
				chk("open erase", q[0], {`FSP_OP_SECT, 6'(lo_t[b] - 1), 16'h0, 8'hff});
			end
		end
		cmd(`FSP_CMD_WREN);
		cmd(`FSP_CMD_BE);
		chk("bulk guarded", status[0], 0);
		wprot_n = 1'b0;
		wrsr(3'h0);
		chk("wp frozen", status[4:2], 7);
		wprot_n = 1'b1;
		wrsr(3'h0);
		cmd(`FSP_CMD_WREN);
		q.delete();
		cmd(`FSP_CMD_BE);
		idle();
		chk("bulk erase", q[0], {`FSP_OP_BULK, 22'h0, 8'hff});
	endtask

	task s_dpd;
		cmd(`FSP_CMD_DPD);
		chk("dpd on", deep_pd, 1);
		cmd(`FSP_CMD_WREN);
		chk("dpd ignores", status[1], 0);
		cmd(`FSP_CMD_RDPD);
		chk("dpd off", deep_pd, 0);
	endtask

	task s_pause;
		i_fsp_spi_master.start();
		i_fsp_spi_master.bits(8'h06, 4, r);
		i_fsp_spi_master.hold(1'b0);
		chk("paused", {paused, sout_oe}, 2'h2);
		i_fsp_spi_master.bits(8'hff, 4, r);
		i_fsp_spi_master.hold(1'b1);
		chk("resumed", paused, 0);
		i_fsp_spi_master.bits(8'h60, 4, r);
		i_fsp_spi_master.stop();
		chk("pause kept state", status[1], 1);
		cmd(`FSP_CMD_WRDI);
		i_fsp_spi_master.start();
		i_fsp_spi_master.bits(8'h06, 4, r);
		i_fsp_spi_master.hold(1'b0);
		i_fsp_spi_master.stop();
		chk("desel unpause", paused, 0);
		i_fsp_spi_master.hold(1'b1);
		i_fsp_spi_master.start();
		i_fsp_spi_master.bits(8'h60, 4, r);
		i_fsp_spi_master.stop();
		chk("iface reset", status[1], 0);
	endtask

	// Main sequence
	initial begin
		wprot_n = 1'b1;
		arr_ready = 1'b0;
		rst_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (40) @(posedge clk_sys);
		s_latch();
		s_prog();
		s_protect();
		s_dpd();
		s_pause();
		summarize();
	end

	// Watchdog
	initial begin
		#1000000;
		miscompares++;
		summarize();
	end
endmodule // fsp_flash_seq_tb

bind fsp_flash_seq fsp_seq_monitor i_fsp_seq_monitor (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_sel_n(i_sel_n), .i_serial_in(i_serial_in),
	.i_pause_n(i_pause_n), .i_wprot_n(i_wprot_n), .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
	.o_arr_valid(o_arr_valid), .o_arr_op(o_arr_op), .o_arr_addr(o_arr_addr), .o_arr_data(o_arr_data),
	.i_arr_ready(i_arr_ready), .o_status(o_status), .o_active(o_active), .o_deep_pd(o_deep_pd), .o_paused(o_paused));

// [testbench/fsp_seq_monitor.sv]
// Port checker for the flash sequencer.
// Assumes it is bound onto fsp_flash_seq with one clock domain.
`timescale 1ns/10ps
`include "fsp_map.vh"
module fsp_seq_monitor (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// Serial link
	input wire i_sclk,
	input wire i_sel_n,
	input wire i_serial_in,
	input wire i_pause_n,
	input wire i_wprot_n,
	input wire o_serial_out,
	input wire o_serial_out_oe,
	// Array port
	input wire o_arr_valid,
	input wire [1:0] o_arr_op,
	input wire [21:0] o_arr_addr,
	input wire [7:0] o_arr_data,
	input wire i_arr_ready,
	// Status
	input wire [7:0] o_status,
	input wire o_active,
	input wire o_deep_pd,
	input wire o_paused
);
	// ============================================================
	// Lowest protected sector for the guard bits
	// ============================================================
	function [6:0] fsp_lo(input [2:0] b);
		case (b)
			3'h0: fsp_lo = 7'h40;
			3'h1: fsp_lo = 7'h3f;
			3'h2: fsp_lo = 7'h3e;
			3'h3: fsp_lo = 7'h3c;
			3'h4: fsp_lo = 7'h38;
			3'h5: fsp_lo = 7'h30;
			3'h6: fsp_lo = 7'h20;
			default: fsp_lo = 7'h00;
		endcase
	endfunction
	wire [6:0] lo_sec = fsp_lo(o_status[4:2]);

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// ============================================================
	// Assertions
	// ============================================================
	dpd_blocks_a: assert property (
		o_deep_pd && $past(o_deep_pd) |-> !$rose(o_status[0])) else $error("cycle started in deep power-down");
	pause_hiz_a: assert property (
		o_paused |-> !o_serial_out_oe) else $error("output driven while paused");
	busy_active_a: assert property (
		o_status[0] |-> o_active) else $error("busy but not active");
	desel_unpause_a: assert property (
		i_sel_n [*5] |-> !o_paused) else $error("pause kept after deselect");
	req_busy_a: assert property (
		o_arr_valid |-> o_status[0]) else $error("array request while idle");
	erase_ones_a: assert property (
		o_arr_valid && o_arr_op != `FSP_OP_PROG |-> o_arr_data == 8'hff) else $error("erase data not ones");
	stall_hold_a: assert property (
		o_arr_valid && !i_arr_ready |=> o_arr_valid && $stable({o_arr_op, o_arr_addr, o_arr_data}))
		else $error("array word lost in stall");
	done_latch_a: assert property (
		$fell(o_status[0]) |-> !o_status[1]) else $error("latch kept after cycle");
	bulk_guard_a: assert property (
		o_arr_valid && o_arr_op == `FSP_OP_BULK |-> o_status[4:2] == 3'h0 && o_arr_addr == 22'h0)
		else $error("bulk erase with guard set");
	region_guard_a: assert property (
		o_arr_valid && o_arr_op != `FSP_OP_BULK |-> {1'b0, o_arr_addr[21:16]} < lo_sec)
		else $error("protected sector altered");
	wp_freeze_a: assert property (
		!i_wprot_n [*4] |=> $stable(o_status[7:2])) else $error("status changed under write protect");
endmodule // fsp_seq_monitor

// [testbench/fsp_spi_master.sv]
// Serial bus master model driving the flash sequencer pins.
// Assumes mode 0: clock low between frames, 160 ns bit period.
`timescale 1ns/10ps
module fsp_spi_master (
	// Serial pins
	output logic o_sclk,
	output logic o_sel_n,
	output logic o_mosi,
	output logic o_pause_n,
	input wire logic i_miso
);
	// Idle levels
	initial begin
		o_sclk = 1'b0;
		o_sel_n = 1'b1;
		o_mosi = 1'b1;
		o_pause_n = 1'b1;
	end

	// ============================================================
	// Frame tasks
	// ============================================================
	// select low before frame
	task start;
		#40 o_sel_n = 1'b0;
		#100;
	endtask

	task stop;
		#80 o_sel_n = 1'b1;
		o_mosi = ~o_mosi;
		#200;
	endtask

	task bits(input logic [7:0] d, input int n, output logic [7:0] r);
		int i;
		r = 8'h00;
		for (i = 0; i < n; i++) begin
			o_mosi = d[7-i];
			#80 o_sclk = 1'b1;
			r = {r[6:0], i_miso};
			#80 o_sclk = 1'b0;
		end
	endtask

	// pause level change with settling time
	task hold(input logic v);
		o_pause_n = v;
		#100;
	endtask
endmodule // fsp_spi_master
